// file: numeric_coprocessor_sync_defs.vh
// Constants for the numeric coprocessor synchronization block
// Notes on behaviour
// - Host forwards only numeric instructions here and runs its own meanwhile.
// - Numeric instructions execute strictly in host stream order.
// - One numeric operation at a time; earlier activity completes first.
// - Coprocessor references memory only after host finished with the operand.
// - Earlier memory references complete before a later instruction starts.
// - Seven control and state instructions synchronize data without a host wait.
// - Those seven request the local bus at once when accepted.
// - Bus held until the instruction finishes, then returned to the host.
// - Unmasked error asserts busy and interrupt; busy never drops meanwhile.
`ifndef NUMERIC_COPROCESSOR_SYNC_DEFS_VH
`define NUMERIC_COPROCESSOR_SYNC_DEFS_VH

// Instruction class codes
`define CODE_W 4
`define CODE_ARITH 4'h0
`define CODE_LOAD_MEM 4'h1
`define CODE_STORE_MEM 4'h2
`define CODE_STORE_STATUS 4'h3
`define CODE_STORE_CONTROL 4'h4
`define CODE_LOAD_CONTROL 4'h5
`define CODE_RESTORE_STATE 4'h6
`define CODE_LOAD_ENV 4'h7
`define CODE_CLEAR_ERROR 4'h8
`define CODE_STORE_STATUS_NOWAIT 4'h9
`define CODE_STORE_CONTROL_NOWAIT 4'hA

// Sequencer states
`define SEQ_STATE_W 3
`define SEQ_IDLE 3'h0
`define SEQ_OPERAND 3'h1
`define SEQ_GRANT 3'h2
`define SEQ_START 3'h3
`define SEQ_RUN 3'h4
`define SEQ_ERROR 3'h5

// Bus ownership states
`define BUS_STATE_W 2
`define BUS_FREE 2'h0
`define BUS_ASK 2'h1
`define BUS_HOLD 2'h2

// Stream sequence tag
`define TAG_W 4
`define TAG_ZERO 4'h0
`define TAG_ONE 4'h1

`endif

// file: coproc_bus_owner.v
// Local bus request, ownership and release for self-synchronizing instructions
`include "numeric_coprocessor_sync_defs.vh"

module coproc_bus_owner (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_request,
  input wire i_grant,
  input wire i_finish,
  output reg o_bus_req,
  output reg o_bus_owned
);

  reg [`BUS_STATE_W-1:0] state;
  reg [`BUS_STATE_W-1:0] next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Ownership sequence
  always @*
  begin
    next_state = state;
    case (state)
      `BUS_FREE:
      begin
        if (i_request)
        begin
          next_state = `BUS_ASK;
        end
      end
      `BUS_ASK:
      begin
        if (i_grant)
        begin
          next_state = `BUS_HOLD;
        end
      end
      `BUS_HOLD:
      begin
        if (i_finish)
        begin
          next_state = `BUS_FREE;
        end
      end
      default:
      begin
        next_state = `BUS_FREE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered state and outputs
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state <= `BUS_FREE;
      o_bus_req <= 1'b0;
      o_bus_owned <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // Request stays up through ownership; its fall is the release
      o_bus_req <= (next_state != `BUS_FREE);
      o_bus_owned <= (next_state == `BUS_HOLD);
    end
  end

endmodule // coproc_bus_owner

// file: numeric_coprocessor_sync.v
// Instruction, data and bus synchronization sequencer of the numeric coprocessor
`include "numeric_coprocessor_sync_defs.vh"

module numeric_coprocessor_sync (
  input wire I_CLK_SYS,
  input wire I_RST_N,
  input wire I_INSTR_VALID,
  input wire [`CODE_W-1:0] I_INSTR_CODE,
  input wire I_INSTR_HAS_MEM,
  input wire I_OPND_ID_DONE,
  input wire I_BUS_GRANT,
  input wire I_EXEC_DONE,
  input wire I_EXEC_ERR,
  output wire O_READY,
  output reg O_BUSY,
  output reg O_INT,
  output reg O_EXEC_START,
  output reg [`CODE_W-1:0] O_EXEC_CODE,
  output reg [`TAG_W-1:0] O_EXEC_TAG,
  output reg O_MEM_EN,
  output wire O_BUS_REQ,
  output wire O_BUS_OWNED
);

  ////////////////////////////////////////////////////////////////////////////
  // Instruction class decoding
  function is_self_sync;
    input [`CODE_W-1:0] code;
    begin
      is_self_sync = (code == `CODE_STORE_STATUS) ||
                     (code == `CODE_STORE_STATUS_NOWAIT) ||
                     (code == `CODE_STORE_CONTROL) ||
                     (code == `CODE_STORE_CONTROL_NOWAIT) ||
                     (code == `CODE_LOAD_CONTROL) ||
                     (code == `CODE_RESTORE_STATE) ||
                     (code == `CODE_LOAD_ENV);
    end
  endfunction

  function needs_memory;
    input [`CODE_W-1:0] code;
    input has_mem;
    begin
      needs_memory = has_mem || is_self_sync(code);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg [`SEQ_STATE_W-1:0] state;
  reg [`SEQ_STATE_W-1:0] next_state;
  reg [`CODE_W-1:0] cur_code;
  reg cur_mem;
  reg cur_sync;
  reg [`TAG_W-1:0] issue_tag;
  reg [`TAG_W-1:0] cur_tag;
  wire accept;
  wire accept_exec;
  wire clear_err;
  wire bus_request;
  wire bus_finish;
  wire bus_owned;
  wire run_end;

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance of instructions from the host stream
  // Only one operation is in flight, so a new one waits for idle
  assign O_READY = (state == `SEQ_IDLE) ||
                   ((state == `SEQ_ERROR) && (I_INSTR_CODE == `CODE_CLEAR_ERROR));
  assign accept = I_INSTR_VALID && O_READY;
  assign accept_exec = accept && (state == `SEQ_IDLE) &&
                       (I_INSTR_CODE != `CODE_CLEAR_ERROR);
  assign clear_err = accept && (state == `SEQ_ERROR);
  assign run_end = (state == `SEQ_RUN) && (I_EXEC_DONE || I_EXEC_ERR);

  ////////////////////////////////////////////////////////////////////////////
  // Bus ownership for self-synchronizing instructions
  assign bus_request = accept_exec && is_self_sync(I_INSTR_CODE);
  assign bus_finish = run_end && cur_sync;

  coproc_bus_owner u_bus_owner (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_request(bus_request),
    .i_grant(I_BUS_GRANT),
    .i_finish(bus_finish),
    .o_bus_req(O_BUS_REQ),
    .o_bus_owned(bus_owned)
  );

  assign O_BUS_OWNED = bus_owned;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @*
  begin
    next_state = state;
    case (state)
      `SEQ_IDLE:
      begin
        if (accept_exec)
        begin
          if (!needs_memory(I_INSTR_CODE, I_INSTR_HAS_MEM))
          begin
            next_state = `SEQ_START;
          end
          else if (!I_OPND_ID_DONE)
          begin
            next_state = `SEQ_OPERAND;
          end
          else if (is_self_sync(I_INSTR_CODE))
          begin
            next_state = `SEQ_GRANT;
          end
          else
          begin
            next_state = `SEQ_START;
          end
        end
      end
      `SEQ_OPERAND:
      begin
        // Host still owns the operand until its identifying read ends
        if (I_OPND_ID_DONE)
        begin
          next_state = cur_sync ? `SEQ_GRANT : `SEQ_START;
        end
      end
      `SEQ_GRANT:
      begin
        if (bus_owned)
        begin
          next_state = `SEQ_START;
        end
      end
      `SEQ_START:
      begin
        next_state = `SEQ_RUN;
      end
      `SEQ_RUN:
      begin
        if (I_EXEC_ERR)
        begin
          next_state = `SEQ_ERROR;
        end
        else if (I_EXEC_DONE)
        begin
          next_state = `SEQ_IDLE;
        end
      end
      `SEQ_ERROR:
      begin
        if (clear_err)
        begin
          next_state = `SEQ_IDLE;
        end
      end
      default:
      begin
        next_state = `SEQ_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State, captured instruction and stream tags
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      state <= `SEQ_IDLE;
      cur_code <= `CODE_ARITH;
      cur_mem <= 1'b0;
      cur_sync <= 1'b0;
      issue_tag <= `TAG_ZERO;
      cur_tag <= `TAG_ZERO;
    end
    else
    begin
      state <= next_state;
      if (accept_exec)
      begin
        cur_code <= I_INSTR_CODE;
        cur_mem <= needs_memory(I_INSTR_CODE, I_INSTR_HAS_MEM);
        cur_sync <= is_self_sync(I_INSTR_CODE);
        // Tags follow the host stream one by one
        cur_tag <= issue_tag;
        issue_tag <= issue_tag + `TAG_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the execution unit and the host
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      O_BUSY <= 1'b0;
      O_INT <= 1'b0;
      O_EXEC_START <= 1'b0;
      O_EXEC_CODE <= `CODE_ARITH;
      O_EXEC_TAG <= `TAG_ZERO;
      O_MEM_EN <= 1'b0;
    end
    else
    begin
      // Busy covers the error wait, so it cannot fall under a raised interrupt
      O_BUSY <= (next_state != `SEQ_IDLE);
      O_INT <= (next_state == `SEQ_ERROR);
      O_EXEC_START <= (next_state == `SEQ_START);
      if (next_state == `SEQ_START)
      begin
        O_EXEC_CODE <= (state == `SEQ_IDLE) ? I_INSTR_CODE : cur_code;
        O_EXEC_TAG <= (state == `SEQ_IDLE) ? issue_tag : cur_tag;
      end
      // Memory access only inside the run; ends before the next start
      O_MEM_EN <= (next_state == `SEQ_RUN) && cur_mem;
    end
  end

endmodule // numeric_coprocessor_sync

// file: numeric_coprocessor_sync_properties.sv
// Port assertions for the coprocessor synchronization block
`include "numeric_coprocessor_sync_defs.vh"
module numeric_coprocessor_sync_properties (
  input wire I_CLK_SYS,
  input wire I_RST_N,
  input wire I_INSTR_VALID,
  input wire [`CODE_W-1:0] I_INSTR_CODE,
  input wire I_INSTR_HAS_MEM,
  input wire I_OPND_ID_DONE,
  input wire I_BUS_GRANT,
  input wire I_EXEC_DONE,
  input wire I_EXEC_ERR,
  input wire O_READY,
  input wire O_BUSY,
  input wire O_INT,
  input wire O_EXEC_START,
  input wire [`CODE_W-1:0] O_EXEC_CODE,
  input wire [`TAG_W-1:0] O_EXEC_TAG,
  input wire O_MEM_EN,
  input wire O_BUS_REQ,
  input wire O_BUS_OWNED
);
  timeunit 1ns;
  timeprecision 1ps;
  wire take = I_INSTR_VALID && O_READY;
  wire sync = I_INSTR_CODE inside {[4'h3:4'h7], 4'h9, 4'hA};
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_N);
  a_start_pulse: assert property (O_EXEC_START |=> !O_EXEC_START)
    else $error("long start");
  a_take_busy: assert property (take && I_INSTR_CODE != 4'h8 |=> O_BUSY)
    else $error("no busy");
  a_busy_refuse: assert property (O_BUSY && !O_INT |-> !O_READY)
    else $error("ready while busy");
  a_int_busy: assert property
    (O_INT && !(take && I_INSTR_CODE == 4'h8) |=> O_INT && O_BUSY)
    else $error("error state lost");
  a_err_int: assert property (O_BUSY && I_EXEC_ERR |=> O_INT && O_BUSY)
    else $error("no interrupt");
  a_req_sync: assert property (take && sync |=> O_BUS_REQ)
    else $error("no bus request");
  a_start_owned: assert property ($rose(O_BUS_OWNED) |=> O_EXEC_START)
    else $error("no start on bus");
  a_bus_held: assert property
    (O_BUS_OWNED && !I_EXEC_DONE && !I_EXEC_ERR |=> O_BUS_OWNED)
    else $error("bus dropped");
  a_bus_free: assert property (O_BUS_OWNED && I_EXEC_DONE |=> !O_BUS_REQ && !O_BUS_OWNED)
    else $error("bus kept");
  a_mem_order: assert property (O_EXEC_START |-> !O_MEM_EN)
    else $error("memory still open");
  a_mem_late: assert property ($rose(O_MEM_EN) |-> $past(O_EXEC_START))
    else $error("early memory");
endmodule // numeric_coprocessor_sync_properties
////////////////////////////////////////////////////////////////////////////////
bind numeric_coprocessor_sync numeric_coprocessor_sync_properties props (.I_CLK_SYS, .I_RST_N,
  .I_INSTR_VALID, .I_INSTR_CODE, .I_INSTR_HAS_MEM, .I_OPND_ID_DONE, .I_BUS_GRANT, .I_EXEC_DONE,
  .I_EXEC_ERR, .O_READY, .O_BUSY, .O_INT, .O_EXEC_START, .O_EXEC_CODE, .O_EXEC_TAG, .O_MEM_EN,
  .O_BUS_REQ, .O_BUS_OWNED);

// file: host_bus_model.sv
// Host model: operand identification pulse and local bus grant
module host_bus_model (
  input logic clk,
  input logic rst_n,
  input logic take,
  input logic mem,
  input logic req,
  input logic [3:0] dly,
  output logic opnd = 1'b0,
  output logic grant = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = -1;
  logic seen = 1'b0;
  always @(posedge clk)
  begin
    opnd <= 1'b0;
    grant <= seen && req && rst_n;
    if (!rst_n || (take && mem))
    begin
      cnt <= rst_n ? int'(dly) : -1;
      seen <= 1'b0;
    end
    else if (cnt == 0)
    begin
      opnd <= 1'b1;
      seen <= 1'b1;
      cnt <= -1;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule // host_bus_model

// file: numeric_coprocessor_sync_bench.sv
// Self-checking bench of the coprocessor synchronization block
module numeric_coprocessor_sync_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, vld = 0, hmem = 0, done = 0, err = 0;
  logic [3:0] code = 0, dly = 0, ctag = 0, xcode, xtag;
  logic rdy, busy, intr, st, men, req, own, opnd, grant;
  logic [3:0] q[$];
  int err_total = 0, num_checks = 0;
  wire [3:0] mon = {busy, own, st, rdy};
  always #5 clk = ~clk;
  numeric_coprocessor_sync dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_INSTR_VALID(vld),
    .I_INSTR_CODE(code), .I_INSTR_HAS_MEM(hmem), .I_OPND_ID_DONE(opnd), .I_BUS_GRANT(grant),
    .I_EXEC_DONE(done), .I_EXEC_ERR(err), .O_READY(rdy), .O_BUSY(busy), .O_INT(intr),
    .O_EXEC_START(st), .O_EXEC_CODE(xcode), .O_EXEC_TAG(xtag), .O_MEM_EN(men),
    .O_BUS_REQ(req), .O_BUS_OWNED(own));
  host_bus_model host (.clk, .rst_n, .take(vld && rdy), .mem(hmem), .req, .dly, .opnd, .grant);
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task print_verdict;
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bounded wait on one monitored output at falling edges
  task automatic wt(input int b, input logic v);
    int n;
    for (n = 0; n < 99 && mon[b] !== v; n++)
      @(negedge clk);
    if (n == 99)
    begin
      err_total++;
      $display("[ERR] %0t got %0h exp %0h", $time, mon[b], v);
      print_verdict;
    end
  endtask
  task automatic offer(input logic [3:0] c, input logic m);
    vld = 1;
    code = c;
    hmem = m;
    wt(0, 1);
    @(negedge clk);
    vld = 0;
  endtask
  task automatic run(input logic [3:0] c, input int d, input logic e);
    logic s, m;
    s = c inside {[4'h3:4'h7], 4'h9, 4'hA};
    m = c != 4'h0 || $urandom % 2;
    dly = $urandom % 4;
    q.push_back(c);
    offer(c, m);
    chk(busy, 1);
    chk(req, s);
    wt(1, 1);
    chk(own, s);
    @(negedge clk);
    chk(men, m);
    repeat (d) @(negedge clk);
    done = !e;
    err = e;
    @(negedge clk);
    done = 0;
    err = 0;
    if (e)
    begin
      repeat (3) @(negedge clk);
      chk({busy, intr, rdy}, 3'h6);
      offer(4'h8, 0);
      // Let an edge pass so the next offer does not rewrite valid in this step
      @(negedge clk);
    end
    wt(3, 0);
    chk({intr, req, own}, 0);
  endtask
  // Start order and tag sequence against the queued stream
  always @(negedge clk)
    if (st === 1'b1)
    begin
      chk(xcode, q.pop_front());
      // Tag counted in the bench from zero after reset, one per executed instruction
      chk(xtag, ctag);
      ctag = ctag + 4'h1;
    end
  initial
  begin
    int i;
    logic [3:0] c;
    void'($urandom(59635));
    repeat (2) @(negedge clk);
    rst_n = 1;
    for (i = 0; i < 40; i++)
    begin
      c = i < 11 ? i : $urandom % 11;
      run(c == 4'h8 ? 4'h0 : c, 1 + $urandom % 5, i % 6 == 4);
    end
    print_verdict;
  end
endmodule // numeric_coprocessor_sync_bench
